// File: phy_evt_pkg.sv
// constants shared by the phy event, counter and strap register block
// assumes a 32-bit apb slave with word-indexed registers
`default_nettype none
package phy_evt_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_EVENT_IRQ = 6'h15;
   localparam logic [5:0] IDX_RX_FAULT = 6'h16;
   localparam logic [5:0] IDX_UNPLUG = 6'h17;
   localparam logic [5:0] IDX_STRAP = 6'h18;
   localparam int ADDR_W = 8;
   localparam int IDX_LSB = 2;

   // event interrupt register fields
   localparam int BIT_IRQ_WAITING = 15;
   localparam int BIT_LINK_SUPPRESS = 12;
   localparam int BIT_DUPLEX_SUPPRESS = 11;
   localparam int BIT_RATE_SUPPRESS = 10;
   localparam int BIT_GLOBAL_SUPPRESS = 8;
   localparam int BIT_DUPLEX_CHANGED = 4;
   localparam int BIT_RATE_CHANGED = 3;
   localparam int BIT_LINK_CHANGED = 2;
   localparam int BIT_IRQ_STATE = 0;
   localparam int MASK_LANE = 1;

   // reset values
   localparam logic SUPPRESS_RESET = 1'b1;
   localparam logic [15:0] STRAP_RESET = 16'hC4E0;
   localparam int RX_FAULT_W = 16;
   localparam int UNPLUG_W = 8;

   // strap pin positions inside the synchronised pin vector
   localparam int PIN_RX_CLK = 10;
   localparam int PIN_RX_ER = 9;
   localparam int SYNC_STAGES = 2;

   // strap capture sequencing after reset release, gray along the path
   typedef enum logic [1:0] {
      ST_SETTLE0 = 2'b00,
      ST_SETTLE1 = 2'b01,
      ST_SAMPLE = 2'b11,
      ST_LATCHED = 2'b10
   } strap_phase_e;
endpackage
`default_nettype wire

// File: pin_sync.sv
// two-flop synchroniser for a vector of pin inputs
// assumes each bit is an independent level from outside the clock domain
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // pins in, synchronised copy out
   input wire logic [WIDTH-1:0] pins_async,
   output logic [WIDTH-1:0] pins_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s r, n;

   always_comb begin
      n.meta = pins_async;
      n.stable = r.meta;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign pins_sync = r.stable;
endmodule
`default_nettype wire

// File: phy_event_counter_strap_regs.sv
// event interrupt, receive error and unplug tallies, and strap capture registers
// assumes an apb master on core_clk, link status levels from logic on core_clk
// and all strap and receive pins arriving asynchronously
//
// What this block does
// - pending bit 15 mirrors status bit, read-cleared
// - duplex suppress bit, reset one, blocks duplex irq
// - rate suppress bit, reset one, blocks rate irq
// - link suppress bit 12, reset one, blocks link irq
// - global suppress bit blocks every interrupt
// - duplex change flag latches high until read
// - rate change flag latches high until read
// - link change flag latches high until read
// - status bit sets on unmasked flag, read-cleared
// - 16-bit receive error tally, cleared by read
// - 8-bit unplug tally, upper bits zero, read-cleared
// - led style strap captured into bit 15
// - interrupt pin strap captured into bit 14
// - cable state strap captured into bit 13
// - isolate strap from tx clock into bit 12
// - reduced mii strap from col into bit 11
// - 10m serial strap from rx clock, bit 10
// - repeater strap from rx error into bit 9
// - test strap from rx data valid, bit 8
// - three opmode straps from indicators, bits 7-5
// - five address straps from crs, rxd, bits 4-0
`default_nettype none
module phy_event_counter_strap_regs
   import phy_evt_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link status levels from the link, speed and duplex logic
   input wire logic link_up,
   input wire logic speed_100,
   input wire logic full_duplex,
   // strap and receive pins
   input wire logic led_style_pin,
   input wire logic irq_pin_sense,
   input wire logic cable_state_pin,
   input wire logic tx_clk_pin,
   input wire logic col_pin,
   input wire logic rx_clk_pin,
   input wire logic rx_er_pin,
   input wire logic rx_dv_pin,
   input wire logic indicator_pin_2,
   input wire logic indicator_pin_1,
   input wire logic indicator_pin_0,
   input wire logic crs_pin,
   input wire logic [3:0] rxd_pin,
   // interrupt pin
   output logic irq_out_n,
   output logic irq_out_oe
);
   typedef struct packed {
      strap_phase_e phase;
      logic [15:0] strap;
      logic link_sup;
      logic dup_sup;
      logic rate_sup;
      logic glob_sup;
      logic dup_chg;
      logic rate_chg;
      logic link_chg;
      logic irq;
      logic [RX_FAULT_W-1:0] rx_cnt;
      logic [UNPLUG_W-1:0] unplug_cnt;
      logic dup_prev;
      logic rate_prev;
      logic link_prev;
      logic rxclk_prev;
      logic [31:0] prdata;
   } state_s;

   state_s r, n;
   logic [15:0] pins_s;
   logic [5:0] idx;
   logic acc;
   logic acc_rd;
   logic acc_wr;
   logic live;
   logic dup_evt;
   logic rate_evt;
   logic link_evt;
   logic unplug_evt;
   logic rx_tick;
   logic clr_event;
   logic clr_rx;
   logic clr_unplug;
   logic irq_cause;
   logic dup_keep;
   logic rate_keep;
   logic link_keep;
   logic rd_covers;

   function automatic logic [5:0] reg_index(logic [ADDR_W-1:0] a);
      return a[IDX_LSB +: 6];
   endfunction

   function automatic logic is_mapped(logic [5:0] i);
      return (i == IDX_EVENT_IRQ) || (i == IDX_RX_FAULT) || (i == IDX_UNPLUG) ||
         (i == IDX_STRAP);
   endfunction

   function automatic logic [31:0] reg_word(logic [5:0] i, state_s s);
      logic [31:0] w;
      w = '0;
      case (i)
         IDX_EVENT_IRQ: begin
            w[BIT_IRQ_WAITING] = s.irq;
            w[BIT_LINK_SUPPRESS] = s.link_sup;
            w[BIT_DUPLEX_SUPPRESS] = s.dup_sup;
            w[BIT_RATE_SUPPRESS] = s.rate_sup;
            w[BIT_GLOBAL_SUPPRESS] = s.glob_sup;
            w[BIT_DUPLEX_CHANGED] = s.dup_chg;
            w[BIT_RATE_CHANGED] = s.rate_chg;
            w[BIT_LINK_CHANGED] = s.link_chg;
            w[BIT_IRQ_STATE] = s.irq;
         end
         IDX_RX_FAULT: w[RX_FAULT_W-1:0] = s.rx_cnt;
         IDX_UNPLUG: w[UNPLUG_W-1:0] = s.unplug_cnt;
         IDX_STRAP: w[15:0] = s.strap;
         default: w = '0;
      endcase
      return w;
   endfunction

   // pins in strap register bit order; rx clock and rx error reuse this path
   pin_sync #(
      .WIDTH(16)
   ) u_pin_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pins_async({led_style_pin, irq_pin_sense, cable_state_pin, tx_clk_pin, col_pin,
         rx_clk_pin, rx_er_pin, rx_dv_pin, indicator_pin_2, indicator_pin_1,
         indicator_pin_0, crs_pin, rxd_pin}),
      .pins_sync(pins_s)
   );

   always_comb begin
      idx = reg_index(paddr);
      acc = psel && penable;
      acc_rd = acc && !pwrite;
      acc_wr = acc && pwrite;
      // change detection only once the previous levels are meaningful
      live = (r.phase == ST_LATCHED);
      dup_evt = live && (full_duplex != r.dup_prev);
      rate_evt = live && (speed_100 != r.rate_prev);
      link_evt = live && (link_up != r.link_prev);
      unplug_evt = live && r.link_prev && !link_up;
      rx_tick = live && pins_s[PIN_RX_CLK] && !r.rxclk_prev && pins_s[PIN_RX_ER];
      clr_event = acc_rd && (idx == IDX_EVENT_IRQ);
      clr_rx = acc_rd && (idx == IDX_RX_FAULT);
      clr_unplug = acc_rd && (idx == IDX_UNPLUG);
      // flags that survive this cycle's read; status is raised from these only
      dup_keep = r.dup_chg && !(clr_event && r.prdata[BIT_DUPLEX_CHANGED]);
      rate_keep = r.rate_chg && !(clr_event && r.prdata[BIT_RATE_CHANGED]);
      link_keep = r.link_chg && !(clr_event && r.prdata[BIT_LINK_CHANGED]);
      rd_covers = (r.prdata[BIT_DUPLEX_CHANGED] == r.dup_chg) &&
         (r.prdata[BIT_RATE_CHANGED] == r.rate_chg) &&
         (r.prdata[BIT_LINK_CHANGED] == r.link_chg) && (r.prdata[BIT_IRQ_STATE] == r.irq);
      irq_cause = !r.glob_sup && ((dup_keep && !r.dup_sup) ||
         (rate_keep && !r.rate_sup) || (link_keep && !r.link_sup));
   end

   always_comb begin
      n = r;
      n.dup_prev = full_duplex;
      n.rate_prev = speed_100;
      n.link_prev = link_up;
      n.rxclk_prev = pins_s[PIN_RX_CLK];

      // straps are taken once the synchroniser carries post-reset pin levels
      case (r.phase)
         ST_SETTLE0: n.phase = ST_SETTLE1;
         ST_SETTLE1: n.phase = ST_SAMPLE;
         ST_SAMPLE: begin
            n.strap = pins_s;
            n.phase = ST_LATCHED;
         end
         ST_LATCHED: n.phase = ST_LATCHED;
         default: n.phase = ST_SETTLE0;
      endcase

      // read data is captured in the setup phase and held through access
      if (psel && !penable) begin
         n.prdata = reg_word(idx, r);
      end

      if (acc_wr && (idx == IDX_EVENT_IRQ) && pstrb[MASK_LANE]) begin
         n.link_sup = pwdata[BIT_LINK_SUPPRESS];
         n.dup_sup = pwdata[BIT_DUPLEX_SUPPRESS];
         n.rate_sup = pwdata[BIT_RATE_SUPPRESS];
         n.glob_sup = pwdata[BIT_GLOBAL_SUPPRESS];
      end

      // a read clears only what it reported; a new event in the same cycle wins
      if (clr_event) begin
         n.dup_chg = dup_keep;
         n.rate_chg = rate_keep;
         n.link_chg = link_keep;
         n.irq = r.irq && !r.prdata[BIT_IRQ_STATE];
      end
      if (dup_evt) begin
         n.dup_chg = 1'b1;
      end
      if (rate_evt) begin
         n.rate_chg = 1'b1;
      end
      if (link_evt) begin
         n.link_chg = 1'b1;
      end
      if (irq_cause) begin
         n.irq = 1'b1;
      end

      // counters wrap; a read subtracts the value it returned
      n.rx_cnt = r.rx_cnt - (clr_rx ? r.prdata[RX_FAULT_W-1:0] : '0) +
         RX_FAULT_W'(rx_tick);
      n.unplug_cnt = r.unplug_cnt - (clr_unplug ? r.prdata[UNPLUG_W-1:0] : '0) +
         UNPLUG_W'(unplug_evt);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r <= '0;
         r.phase <= ST_SETTLE0;
         r.strap <= STRAP_RESET;
         r.link_sup <= SUPPRESS_RESET;
         r.dup_sup <= SUPPRESS_RESET;
         r.rate_sup <= SUPPRESS_RESET;
         r.glob_sup <= SUPPRESS_RESET;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = 1'b1;
   assign pslverr = acc && !is_mapped(idx);
   // pin stays released until its strap level has been taken
   assign irq_out_oe = (r.phase == ST_LATCHED);
   assign irq_out_n = !r.irq;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_event_read;
      psel && !penable && !pwrite && (idx == IDX_EVENT_IRQ) ##1 acc_rd;
   endsequence

   sequence seq_rx_edge;
      !r.rxclk_prev ##0 pins_s[PIN_RX_CLK] && pins_s[PIN_RX_ER] && live;
   endsequence

   chk_pend_mirror: assert property (
      seq_event_read |-> (prdata[BIT_IRQ_WAITING] == prdata[BIT_IRQ_STATE]))
      else $error("pending bit differs from status bit");

   chk_duplex_gate: assert property (
      (r.dup_sup && r.dup_chg && !r.rate_chg && !r.link_chg && !r.irq && !rate_evt &&
         !link_evt) |=> !r.irq)
      else $error("suppressed duplex change raised interrupt");

   chk_rate_gate: assert property (
      (r.rate_sup && r.rate_chg && !r.dup_chg && !r.link_chg && !r.irq && !dup_evt &&
         !link_evt) |=> !r.irq)
      else $error("suppressed rate change raised interrupt");

   chk_link_gate: assert property (
      (r.link_sup && r.link_chg && !r.dup_chg && !r.rate_chg && !r.irq && !dup_evt &&
         !rate_evt) |=> !r.irq)
      else $error("suppressed link change raised interrupt");

   chk_master_gate: assert property (
      (r.glob_sup && !r.irq) |=> !r.irq)
      else $error("interrupt raised under global suppress");

   chk_duplex_latch: assert property (
      (dup_evt || (r.dup_chg && !clr_event)) |=> r.dup_chg)
      else $error("duplex change flag not held");

   chk_rate_latch: assert property (
      (rate_evt || (r.rate_chg && !clr_event)) |=> r.rate_chg)
      else $error("rate change flag not held");

   chk_link_latch: assert property (
      (link_evt || (r.link_chg && !clr_event)) |=> r.link_chg)
      else $error("link change flag not held");

   chk_irq_raise: assert property (
      (!r.glob_sup && r.link_chg && !r.link_sup && !clr_event) |=> r.irq ##0 !irq_out_n)
      else $error("unmasked change did not raise interrupt");

   chk_rx_count: assert property (
      (seq_rx_edge ##0 !clr_rx) |=> (r.rx_cnt == $past(r.rx_cnt) + 16'h0001))
      else $error("receive error not counted");

   chk_unplug_count: assert property (
      (unplug_evt && !clr_unplug) |=> (r.unplug_cnt == $past(r.unplug_cnt) + 8'h01))
      else $error("disconnect not counted");

   chk_strap_take: assert property (
      (r.phase == ST_SAMPLE) |=> (r.strap == $past(pins_s)) ##1 $stable(r.strap))
      else $error("strap levels not captured or not held");

   chk_irq_release: assert property (
      (seq_event_read ##0 rd_covers) |=> irq_out_n)
      else $error("interrupt pin not released after read");

   chk_duplex_clear: assert property (
      (clr_event && r.prdata[BIT_DUPLEX_CHANGED] && !dup_evt) |=> !r.dup_chg)
      else $error("duplex change flag not cleared by read");

   chk_rate_clear: assert property (
      (clr_event && r.prdata[BIT_RATE_CHANGED] && !rate_evt) |=> !r.rate_chg)
      else $error("rate change flag not cleared by read");

   chk_link_clear: assert property (
      (clr_event && r.prdata[BIT_LINK_CHANGED] && !link_evt) |=> !r.link_chg)
      else $error("link change flag not cleared by read");

   chk_rx_clear: assert property (
      (clr_rx && !rx_tick && (r.prdata[RX_FAULT_W-1:0] == r.rx_cnt)) |=>
         (r.rx_cnt == 16'h0000))
      else $error("receive error tally not cleared by read");

   chk_unplug_clear: assert property (
      (clr_unplug && !unplug_evt && (r.prdata[UNPLUG_W-1:0] == r.unplug_cnt)) |=>
         (r.unplug_cnt == 8'h00))
      else $error("disconnect tally not cleared by read");

   chk_mask_write: assert property (
      (acc_wr && (idx == IDX_EVENT_IRQ) && pstrb[MASK_LANE]) |=>
         (r.glob_sup == $past(pwdata[BIT_GLOBAL_SUPPRESS])))
      else $error("global suppress bit not written");
endmodule
`default_nettype wire

// File: line_side_model.sv
// line side model: drives the receive clock and receive error pins
// assumes the bench calls burst() or hold() and nothing else drives these pins
`default_nettype none
module line_side_model (
   // pins towards the block
   output var logic rx_clk_pin,
   output var logic rx_er_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      rx_clk_pin = 1'b0;
      rx_er_pin = 1'b0;
   end
   // clock runs only inside a burst; error level moves while the clock is low
   task automatic burst(input int n, input logic er);
      #37;
      rx_er_pin = er;
      repeat (n) begin
         #100 rx_clk_pin = 1'b1;
         #100 rx_clk_pin = 1'b0;
      end
      rx_er_pin = 1'b0;
   endtask
   // parks both pins at fixed levels, used while straps are sampled
   task automatic hold(input logic clk_level, input logic er_level);
      rx_clk_pin <= clk_level;
      rx_er_pin <= er_level;
   endtask
endmodule
`default_nettype wire

// File: phy_event_counter_strap_regs_bench.sv
// self-checking bench for the event, tally and strap register block
// assumes an apb slave that may stretch access and a line model for the receive pins
`default_nettype none
module phy_event_counter_strap_regs_bench
   import phy_evt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] A_EVT = {IDX_EVENT_IRQ, 2'b00};
   localparam logic [7:0] A_ERR = {IDX_RX_FAULT, 2'b00};
   localparam logic [7:0] A_UNP = {IDX_UNPLUG, 2'b00};
   localparam logic [7:0] A_STRAP = {IDX_STRAP, 2'b00};
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr, irq_out_n, irq_out_oe, rx_clk_pin, rx_er_pin;
   logic link_up = 1'b1;
   logic speed_100 = 1'b0;
   logic full_duplex = 1'b0;
   logic [15:0] straps = 16'h71BA;
   logic [31:0] mword;
   int mbit [3] = '{BIT_DUPLEX_SUPPRESS, BIT_RATE_SUPPRESS, BIT_LINK_SUPPRESS};
   int fbit [3] = '{BIT_DUPLEX_CHANGED, BIT_RATE_CHANGED, BIT_LINK_CHANGED};
   int fails = 0;
   int n_tests = 0;

   always #12.5 core_clk = ~core_clk;

   line_side_model model (.rx_clk_pin(rx_clk_pin), .rx_er_pin(rx_er_pin));
   phy_event_counter_strap_regs dut (
      .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up(link_up),
      .speed_100(speed_100), .full_duplex(full_duplex),
      .led_style_pin(straps[15]), .irq_pin_sense(straps[14]),
      .cable_state_pin(straps[13]), .tx_clk_pin(straps[12]), .col_pin(straps[11]),
      .rx_clk_pin(rx_clk_pin), .rx_er_pin(rx_er_pin), .rx_dv_pin(straps[8]),
      .indicator_pin_2(straps[7]), .indicator_pin_1(straps[6]),
      .indicator_pin_0(straps[5]), .crs_pin(straps[4]), .rxd_pin(straps[3:0]),
      .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe));

   task automatic end_of_test();
      if (fails == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge core_clk);
      end
      if (pready !== 1'b1) begin
         fails++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(a, 1'b1, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      xfer(a, 1'b0, 32'h0, q, e);
      chk(q, exp);
   endtask

   // toggles one status level and lets flag and status settle
   task automatic toggle(input int i);
      @(posedge core_clk);
      case (i)
         0: full_duplex <= ~full_duplex;
         1: speed_100 <= ~speed_100;
         default: link_up <= ~link_up;
      endcase
      repeat (3) @(posedge core_clk);
   endtask

   initial begin
      logic [31:0] q;
      logic e;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      straps <= ~straps;
      chk({31'h0, irq_out_oe}, 32'h1);
      chk({31'h0, irq_out_n}, 32'h1);
      rd(A_EVT, 32'h1D00);
      rd(A_ERR, 32'h0);
      rd(A_UNP, 32'h0);
      wr(A_STRAP, 32'h0000FFFF);
      rd(A_STRAP, 32'h71BA);
      xfer(8'h64, 1'b0, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      toggle(0);
      chk({31'h0, irq_out_n}, 32'h1);
      rd(A_EVT, 32'h1D10);
      rd(A_EVT, 32'h1D00);
      toggle(1);
      chk({31'h0, irq_out_n}, 32'h1);
      rd(A_EVT, 32'h1D08);
      for (int i = 0; i < 3; i++) begin
         mword = 32'h1C00 & ~(32'h1 << mbit[i]);
         wr(A_EVT, mword);
         toggle(i);
         chk({31'h0, irq_out_n}, 32'h0);
         rd(A_EVT, mword | (32'h1 << fbit[i]) | 32'h8001);
         rd(A_EVT, mword);
         chk({31'h0, irq_out_n}, 32'h1);
      end
      rd(A_UNP, 32'h1);
      rd(A_UNP, 32'h0);
      wr(A_EVT, 32'h1C00);
      toggle(2);
      chk({31'h0, irq_out_n}, 32'h1);
      rd(A_EVT, 32'h1C04);
      wr(A_EVT, 32'h0100);
      toggle(1);
      chk({31'h0, irq_out_n}, 32'h1);
      rd(A_EVT, 32'h0108);
      model.burst(5, 1'b1);
      repeat (6) @(posedge core_clk);
      rd(A_ERR, 32'h5);
      model.burst(3, 1'b0);
      repeat (6) @(posedge core_clk);
      rd(A_ERR, 32'h0);
      rd(A_STRAP, 32'h71BA);
      rst_n <= 1'b0;
      model.hold(1'b1, 1'b1);
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      model.hold(1'b0, 1'b0);
      rd(A_STRAP, 32'h8E45);
      rd(A_ERR, 32'h0);
      rd(A_EVT, 32'h1D00);
      end_of_test();
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire
